// ---- src/gptm_map.svh ----
`ifndef GPTM_MAP_SVH
`define GPTM_MAP_SVH
// ==========================================================================
// Register offsets (byte addresses, one word each)
`define CFG_OFS 8'h00
`define MODE_A_OFS 8'h04
`define MODE_B_OFS 8'h08
`define CTL_OFS 8'h0c
`define IMR_OFS 8'h18
`define RIS_OFS 8'h1c
`define MIS_OFS 8'h20
`define ICR_OFS 8'h24
`define LOAD_A_OFS 8'h28
`define LOAD_B_OFS 8'h2c
`define MATCH_A_OFS 8'h30
`define MATCH_B_OFS 8'h34
`define PRE_A_OFS 8'h38
`define PRE_B_OFS 8'h3c
`define PMATCH_A_OFS 8'h40
`define PMATCH_B_OFS 8'h44
`define VALUE_A_OFS 8'h48
`define VALUE_B_OFS 8'h4c
`define RTC_MATCH_OFS 8'h50
// ==========================================================================
// Control register field positions, half B is half A plus 8
`define CTL_EN 0
`define CTL_STALL 1
`define CTL_TRIG 5
`define CTL_INV 6
`define CTL_B_OFS 8
// ==========================================================================
// Interrupt bit positions
`define IRQ_A_TIMEOUT 0
`define IRQ_A_CMATCH 1
`define IRQ_A_CEVENT 2
`define IRQ_RTC 3
`define IRQ_B_TIMEOUT 8
`define IRQ_B_CMATCH 9
`define IRQ_B_CEVENT 10
`define IRQ_ALL 32'h0000070f
// ==========================================================================
// Reset values
`define LOAD_RST 16'hffff
`define CFG_RST 3'h0
`endif

// ---- src/gptm_pkg.sv ----
package gptm_pkg;
  // Top-level configuration field
  typedef enum logic [2:0] {
    CFG_32_TIMER = 3'b000,
    CFG_32_RTC = 3'b001,
    CFG_16_PAIR = 3'b100
  } cfg_t;
  // Per-half mode field
  typedef enum logic [2:0] {
    MODE_ONE_SHOT = 3'b001,
    MODE_PERIODIC = 3'b010,
    MODE_CAP_COUNT = 3'b011,
    MODE_CAP_TIME = 3'b111,
    MODE_PWM = 3'b110
  } mode_t;
endpackage

// ---- src/timer_half.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "gptm_map.svh"
// ==========================================================================
// One 16-bit half with 8-bit prescaler
module timer_half #(
  parameter int W = 16,
  parameter int PW = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic run,
  input wire logic use_pre,
  input wire gptm_pkg::mode_t mode,
  input wire logic load_wr,
  input wire logic [W-1:0] load,
  input wire logic [W-1:0] match,
  input wire logic [PW-1:0] pre,
  input wire logic [PW-1:0] pmatch,
  input wire logic edge_in,
  output logic [W-1:0] count,
  output logic [PW-1:0] pcount,
  output logic timeout,
  output logic cmatch,
  output logic cevent,
  output logic pwm_hi
);
  logic active;
  wire periodic = (mode == gptm_pkg::MODE_PERIODIC);
  wire pwm = (mode == gptm_pkg::MODE_PWM);
  wire capcnt = (mode == gptm_pkg::MODE_CAP_COUNT);
  wire captime = (mode == gptm_pkg::MODE_CAP_TIME);
  wire cap_mode = capcnt | captime;
  wire pre_done = !use_pre || (pcount == '0);
  wire tick = cap_mode ? edge_in : pre_done;
  wire at_zero = (count == '0);
  wire match_hit = (count == match) && (!use_pre || pcount == pmatch);
  wire restart = periodic | pwm;
  wire [PW-1:0] next_pcount = pre_done ? pre : pcount - 1'b1;
  wire [W-1:0] next_count = at_zero ? load : count - 1'b1;
  // One-shot parks at zero rather than reloading
  wire hold_zero = at_zero && !restart && !cap_mode;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count <= `LOAD_RST;
      pcount <= '0;
      active <= 1'b1;
      timeout <= 1'b0;
      cmatch <= 1'b0;
      cevent <= 1'b0;
      pwm_hi <= 1'b0;
    end else if (ce) begin
      timeout <= 1'b0;
      cmatch <= 1'b0;
      cevent <= 1'b0;
      if (load_wr) begin
        count <= load;
        pcount <= pre;
        active <= 1'b1;
      end else if (run && active) begin
        if (!cap_mode) pcount <= next_pcount;
        if (captime && edge_in) cevent <= 1'b1;
        if (tick) begin
          if (!hold_zero) count <= next_count;
          if (capcnt && match_hit) cmatch <= 1'b1;
          if (at_zero && !cap_mode) begin
            timeout <= 1'b1;
            if (!restart) active <= 1'b0;
          end
        end
      end
      pwm_hi <= pwm && run && (count > match);
    end
  end
endmodule
`default_nettype wire

// ---- src/gptm_ctrl.sv ----
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "gptm_map.svh"
// Overview of operation
// - Invert setting makes PWM output active low
// - Stall setting stops half during debug halt
// - Trigger output only active when enabled
// - Halves enabled separately or together; disabled halts
// - Seven interrupt sources: per half plus RTC
// - Per-source enable gates processor interrupt
// - Write-one clears only the named sources
// - Raw and masked status both readable
// - Load write reloads running counter at once
// - Combined timer uses half A registers only; half B load and match writes still change its upper half
// - Match value sets capture match, PWM duty
// - Prescaler active only in 16-bit modes
// - One-shot stops at zero, periodic reloads; combined one-shot low half keeps reloading from load_a
// - Prescale and prescale match take 0..255
// - PWM drives edge-aligned pulse on capture pin
module gptm_ctrl #(
  parameter int AW = 8
) (
  // Clock, reset, enable
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  // Register port
  input wire logic [AW-1:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  // Debug halt and RTC tick
  input wire logic DEBUG_HALT,
  input wire logic RTC_TICK,
  // Capture pins
  input wire logic CCP_A_IN,
  input wire logic CCP_B_IN,
  output logic CCP_A_OUT,
  output logic CCP_A_OE,
  output logic CCP_B_OUT,
  output logic CCP_B_OE,
  // Triggers and interrupt
  output logic TRIG_A,
  output logic TRIG_B,
  output logic IRQ
);
  // ========================================================================
  // Input synchronisers
  logic [1:0] halt_s, rtc_s, a_s, b_s;
  logic rtc_d, a_d, b_d;
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      halt_s <= '0;
      rtc_s <= '0;
      a_s <= '0;
      b_s <= '0;
      rtc_d <= 1'b0;
      a_d <= 1'b0;
      b_d <= 1'b0;
    end else if (CE) begin
      halt_s <= {halt_s[0], DEBUG_HALT};
      rtc_s <= {rtc_s[0], RTC_TICK};
      a_s <= {a_s[0], CCP_A_IN};
      b_s <= {b_s[0], CCP_B_IN};
      rtc_d <= rtc_s[1];
      a_d <= a_s[1];
      b_d <= b_s[1];
    end
  end
  wire halted = halt_s[1];
  wire rtc_edge = rtc_s[1] & ~rtc_d;
  wire a_edge = a_s[1] & ~a_d;
  wire b_edge = b_s[1] & ~b_d;

  // ========================================================================
  // Registers
  gptm_pkg::cfg_t cfg;
  gptm_pkg::mode_t mode_a, mode_b;
  logic [15:0] ctl, load_a, load_b, match_a, match_b;
  logic [7:0] pre_a, pre_b, pmatch_a, pmatch_b;
  logic [31:0] imr, ris, rtc_match, rtc_count;

  function automatic logic hit(input logic [AW-1:0] a, input logic [7:0] o);
    hit = (a == AW'(o));
  endfunction

  wire wr_cfg = WR && hit(ADDR, `CFG_OFS);
  wire wr_ma = WR && hit(ADDR, `MODE_A_OFS);
  wire wr_mb = WR && hit(ADDR, `MODE_B_OFS);
  wire wr_ctl = WR && hit(ADDR, `CTL_OFS);
  wire wr_imr = WR && hit(ADDR, `IMR_OFS);
  wire wr_icr = WR && hit(ADDR, `ICR_OFS);
  wire wr_la = WR && hit(ADDR, `LOAD_A_OFS);
  wire wr_lb = WR && hit(ADDR, `LOAD_B_OFS);
  wire wr_mta = WR && hit(ADDR, `MATCH_A_OFS);
  wire wr_mtb = WR && hit(ADDR, `MATCH_B_OFS);
  wire wr_pa = WR && hit(ADDR, `PRE_A_OFS);
  wire wr_pb = WR && hit(ADDR, `PRE_B_OFS);
  wire wr_pma = WR && hit(ADDR, `PMATCH_A_OFS);
  wire wr_pmb = WR && hit(ADDR, `PMATCH_B_OFS);
  wire wr_rtcm = WR && hit(ADDR, `RTC_MATCH_OFS);

  wire pair = (cfg == gptm_pkg::CFG_16_PAIR);
  wire rtc_mode = (cfg == gptm_pkg::CFG_32_RTC);
  wire en_a = ctl[`CTL_EN];
  wire en_b = ctl[`CTL_B_OFS + `CTL_EN];
  // Stall only when selected; otherwise debug halt is ignored
  wire run_a = en_a && !(halted && ctl[`CTL_STALL]);
  wire run_b = en_b && !(halted && ctl[`CTL_B_OFS + `CTL_STALL]);

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cfg <= gptm_pkg::CFG_32_TIMER;
      mode_a <= gptm_pkg::MODE_ONE_SHOT;
      mode_b <= gptm_pkg::MODE_ONE_SHOT;
      ctl <= '0;
      imr <= '0;
      load_a <= `LOAD_RST;
      load_b <= `LOAD_RST;
      match_a <= `LOAD_RST;
      match_b <= `LOAD_RST;
      pre_a <= '0;
      pre_b <= '0;
      pmatch_a <= '0;
      pmatch_b <= '0;
      rtc_match <= '1;
    end else if (CE) begin
      if (wr_cfg) cfg <= gptm_pkg::cfg_t'(WDATA[2:0]);
      if (wr_ma) mode_a <= gptm_pkg::mode_t'(WDATA[2:0]);
      if (wr_mb) mode_b <= gptm_pkg::mode_t'(WDATA[2:0]);
      if (wr_ctl) ctl <= WDATA[15:0];
      if (wr_imr) imr <= WDATA & `IRQ_ALL;
      if (wr_la) load_a <= WDATA[15:0];
      if (wr_lb) load_b <= WDATA[15:0];
      // Combined mode keeps upper half in half B registers
      if (wr_la && !pair) load_b <= WDATA[31:16];
      if (wr_mta) match_a <= WDATA[15:0];
      if (wr_mta && !pair) match_b <= WDATA[31:16];
      if (wr_mtb) match_b <= WDATA[15:0];
      if (wr_pa) pre_a <= WDATA[7:0];
      if (wr_pb) pre_b <= WDATA[7:0];
      if (wr_pma) pmatch_a <= WDATA[7:0];
      if (wr_pmb) pmatch_b <= WDATA[7:0];
      if (wr_rtcm) rtc_match <= WDATA;
    end
  end

  // ========================================================================
  // Counters: two halves, chained in 32-bit mode
  logic [15:0] cnt_a, cnt_b;
  logic [7:0] pc_a, pc_b;
  logic to_a, to_b, cm_a, cm_b, ce_a, ce_b, pw_a, pw_b;
  wire chain_tick = !pair && (cnt_a == '0) && run_a;
  wire ld_b = (wr_lb && pair) || (wr_la && !pair);
  // Bus data only on a write; wraps reload the stored value
  // Combined low half wraps through ffff until the high half is zero
  wire [15:0] rel_a = (pair || cnt_b == 16'h0) ? load_a : 16'hffff;
  wire [15:0] ld_val_a = wr_la ? WDATA[15:0] : rel_a;
  wire [15:0] ld_b_wr = pair ? WDATA[15:0] : WDATA[31:16];
  wire [15:0] ld_val_b = ld_b ? ld_b_wr : load_b;
  gptm_pkg::mode_t mode_a_eff, mode_b_eff;
  assign mode_a_eff = pair ? mode_a : gptm_pkg::MODE_PERIODIC;
  assign mode_b_eff = pair ? mode_b : mode_a;

  timer_half u_half_a (
    .clk(CLK),
    .rst_n(RST_N),
    .ce(CE),
    .run(run_a && !rtc_mode),
    .use_pre(pair),
    .mode(mode_a_eff),
    .load_wr(wr_la),
    .load(ld_val_a),
    .match(match_a),
    .pre(pre_a),
    .pmatch(pmatch_a),
    .edge_in(a_edge),
    .count(cnt_a),
    .pcount(pc_a),
    .timeout(to_a),
    .cmatch(cm_a),
    .cevent(ce_a),
    .pwm_hi(pw_a)
  );

  timer_half u_half_b (
    .clk(CLK),
    .rst_n(RST_N),
    .ce(CE),
    .run(pair ? run_b : chain_tick && !rtc_mode),
    .use_pre(pair),
    .mode(mode_b_eff),
    .load_wr(ld_b),
    .load(ld_val_b),
    .match(match_b),
    .pre(pre_b),
    .pmatch(pmatch_b),
    .edge_in(b_edge),
    .count(cnt_b),
    .pcount(pc_b),
    .timeout(to_b),
    .cmatch(cm_b),
    .cevent(ce_b),
    .pwm_hi(pw_b)
  );

  // Low half reloads from load_a on the wrap where B is zero; combined timeout is B's
  wire to32 = !pair && to_b && (cnt_a == load_a);

  // ========================================================================
  // RTC counter, counts synchronised one-second ticks
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rtc_count <= '0;
    end else if (CE && rtc_mode && en_a && rtc_edge) begin
      rtc_count <= rtc_count + 32'h1;
    end
  end
  wire rtc_hit = rtc_mode && en_a && rtc_edge && (rtc_count == rtc_match);

  // ========================================================================
  // Interrupt status
  logic [31:0] ev;
  always_comb begin
    ev = '0;
    ev[`IRQ_A_TIMEOUT] = pair ? to_a : to32;
    ev[`IRQ_A_CMATCH] = cm_a;
    ev[`IRQ_A_CEVENT] = ce_a;
    ev[`IRQ_RTC] = rtc_hit;
    ev[`IRQ_B_TIMEOUT] = pair && to_b;
    ev[`IRQ_B_CMATCH] = pair && cm_b;
    ev[`IRQ_B_CEVENT] = pair && ce_b;
  end
  wire [31:0] clr = wr_icr ? WDATA : '0;
  // Set wins over a clear in the same cycle
  wire [31:0] next_ris = ((ris & ~clr) | ev) & `IRQ_ALL;
  wire [31:0] mis = ris & imr;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ris <= '0;
      IRQ <= 1'b0;
    end else if (CE) begin
      ris <= next_ris;
      IRQ <= |(next_ris & imr);
    end
  end

  // ========================================================================
  // Pins and triggers
  wire pwm_a = pair && mode_a == gptm_pkg::MODE_PWM && en_a;
  wire pwm_b = pair && mode_b == gptm_pkg::MODE_PWM && en_b;
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      CCP_A_OUT <= 1'b0;
      CCP_B_OUT <= 1'b0;
      CCP_A_OE <= 1'b0;
      CCP_B_OE <= 1'b0;
      TRIG_A <= 1'b0;
      TRIG_B <= 1'b0;
    end else if (CE) begin
      CCP_A_OE <= pwm_a;
      CCP_B_OE <= pwm_b;
      CCP_A_OUT <= pw_a ^ ctl[`CTL_INV];
      CCP_B_OUT <= pw_b ^ ctl[`CTL_B_OFS + `CTL_INV];
      TRIG_A <= ctl[`CTL_TRIG] && ev[`IRQ_A_TIMEOUT];
      TRIG_B <= ctl[`CTL_B_OFS + `CTL_TRIG] && to_b && pair;
    end
  end

  // ========================================================================
  // Read data, one cycle after the strobe
  wire [31:0] load_a_rd = pair ? {16'h0, load_a} : {load_b, load_a};
  wire [31:0] match_a_rd = pair ? {16'h0, match_a} : {match_b, match_a};
  wire [31:0] cnt_pair = {8'h0, pc_a, cnt_a};
  wire [31:0] value_a_rd =
    rtc_mode ? rtc_count : pair ? cnt_pair : {cnt_b, cnt_a};
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    if (hit(ADDR, `CFG_OFS)) rd_mux = {29'h0, cfg};
    if (hit(ADDR, `MODE_A_OFS)) rd_mux = {29'h0, mode_a};
    if (hit(ADDR, `MODE_B_OFS)) rd_mux = {29'h0, mode_b};
    if (hit(ADDR, `CTL_OFS)) rd_mux = {16'h0, ctl};
    if (hit(ADDR, `IMR_OFS)) rd_mux = imr;
    if (hit(ADDR, `RIS_OFS)) rd_mux = ris;
    if (hit(ADDR, `MIS_OFS)) rd_mux = mis;
    if (hit(ADDR, `LOAD_A_OFS)) rd_mux = load_a_rd;
    if (hit(ADDR, `LOAD_B_OFS)) rd_mux = {16'h0, load_b};
    if (hit(ADDR, `MATCH_A_OFS)) rd_mux = match_a_rd;
    if (hit(ADDR, `MATCH_B_OFS)) rd_mux = {16'h0, match_b};
    if (hit(ADDR, `PRE_A_OFS)) rd_mux = {24'h0, pre_a};
    if (hit(ADDR, `PRE_B_OFS)) rd_mux = {24'h0, pre_b};
    if (hit(ADDR, `PMATCH_A_OFS)) rd_mux = {24'h0, pmatch_a};
    if (hit(ADDR, `PMATCH_B_OFS)) rd_mux = {24'h0, pmatch_b};
    if (hit(ADDR, `VALUE_A_OFS)) rd_mux = value_a_rd;
    if (hit(ADDR, `VALUE_B_OFS)) rd_mux = {8'h0, pc_b, cnt_b};
    if (hit(ADDR, `RTC_MATCH_OFS)) rd_mux = rtc_match;
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      RDATA <= '0;
    end else if (CE) begin
      RDATA <= RD ? rd_mux : '0;
    end
  end
endmodule
`default_nettype wire

// ---- bench/gptm_ctrl_properties.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "gptm_map.svh"
// ==========================================
// Port checker, CE assumed held high
module gptm_ctrl_properties #(
  parameter int AW = 8
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Register port
  input wire logic [AW-1:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [31:0] RDATA,
  // Outputs
  input wire logic CCP_A_OE,
  input wire logic CCP_B_OE,
  input wire logic TRIG_A,
  input wire logic TRIG_B,
  input wire logic IRQ
);
  logic [31:0] imr;
  logic [15:0] ctl;
  logic [15:0] load_a;
  wire hit_imr = WR && ADDR == `IMR_OFS;
  wire hit_ctl = WR && ADDR == `CTL_OFS;
  wire hit_load = WR && ADDR == `LOAD_A_OFS;
  // Shadows of software writes
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      imr <= 32'h0;
      ctl <= 16'h0;
      load_a <= 16'hffff;
    end else begin
      if (hit_imr) imr <= WDATA;
      if (hit_ctl) ctl <= WDATA[15:0];
      if (hit_load) load_a <= WDATA[15:0];
    end
  end
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  sequence s_rd_load;
    RD && ADDR == `LOAD_A_OFS;
  endsequence
  // Three cycles: enable, registered half, registered output
  sequence s_off(logic b);
    !b [*3];
  endsequence
  property p_load_rb;
    s_rd_load |=> RDATA[15:0] == $past(load_a);
  endproperty
  property p_rd_idle;
    !RD |=> RDATA == 32'h0;
  endproperty
  property p_irq_mask;
    imr == 32'h0 [*2] |-> !IRQ;
  endproperty
  property p_trig_a;
    s_off(ctl[`CTL_TRIG]) |-> !TRIG_A;
  endproperty
  property p_trig_b;
    s_off(ctl[`CTL_TRIG+`CTL_B_OFS]) |-> !TRIG_B;
  endproperty
  property p_oe_a;
    s_off(ctl[`CTL_EN]) |-> !CCP_A_OE;
  endproperty
  property p_oe_b;
    s_off(ctl[`CTL_EN+`CTL_B_OFS]) |-> !CCP_B_OE;
  endproperty
  property p_irq_ev;
    TRIG_A && imr[`IRQ_A_TIMEOUT] |-> ##[0:2] IRQ;
  endproperty
  property p_trig_pulse;
    $rose(TRIG_B) |=> !TRIG_B;
  endproperty
  a_load_rb: assert property (p_load_rb)
    else $error("load read back differs");
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not idle");
  a_irq_mask: assert property (p_irq_mask)
    else $error("irq with all sources masked");
  a_trig_a: assert property (p_trig_a)
    else $error("trigger a while disabled");
  a_trig_b: assert property (p_trig_b)
    else $error("trigger b while disabled");
  a_oe_a: assert property (p_oe_a)
    else $error("pin a driven while half off");
  a_oe_b: assert property (p_oe_b)
    else $error("pin b driven while half off");
  a_irq_ev: assert property (p_irq_ev)
    else $error("timeout did not raise irq");
  a_trig_pulse: assert property (p_trig_pulse)
    else $error("trigger longer than a cycle");
endmodule
bind gptm_ctrl gptm_ctrl_properties #(.AW(AW)) i_props (
  .CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .CCP_A_OE(CCP_A_OE),
  .CCP_B_OE(CCP_B_OE), .TRIG_A(TRIG_A), .TRIG_B(TRIG_B), .IRQ(IRQ)
);
`default_nettype wire

// ---- bench/gptm_far_side.sv ----
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Debug halt source and capture pin stimulus
module gptm_far_side (
  // Clock
  input wire logic clk,
  // Requests
  input wire logic halt_req,
  input wire logic edges_on,
  // Lines toward the timer
  output logic debug_halt,
  output logic ccp_a,
  output logic ccp_b,
  output logic rtc_tick
);
  logic halt = 1'b0;
  logic tog = 1'b0;
  logic [2:0] div = 3'h0;
  // Slow toggle so the 2 FF synchroniser sees every edge
  always_ff @(posedge clk) begin
    halt <= halt_req;
    div <= div + 3'h1;
    tog <= edges_on ? tog ^ (div == 3'h7) : 1'b0;
  end
  assign debug_halt = halt;
  assign ccp_a = tog;
  assign ccp_b = tog;
  assign rtc_tick = tog;
endmodule
`default_nettype wire

// ---- bench/gptm_ctrl_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "gptm_map.svh"
// ==========================================
// Self-checking bench
module gptm_ctrl_tb;
  logic CLK, RST_N, WR, RD, halt_req, edges_on;
  logic [7:0] ADDR;
  logic [31:0] WDATA, RDATA, v, w;
  logic DEBUG_HALT, CCP_A_IN, CCP_B_IN, CCP_A_OUT, CCP_A_OE;
  logic CCP_B_OUT, CCP_B_OE, TRIG_A, TRIG_B, IRQ;
  logic ce, rtc_tick;
  int fail_count = 0;
  int check_count = 0;
  int n;
  gptm_ctrl #(.AW(8)) i_dut (.CLK(CLK), .RST_N(RST_N), .CE(ce),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .DEBUG_HALT(DEBUG_HALT), .RTC_TICK(rtc_tick), .CCP_A_IN(CCP_A_IN),
    .CCP_B_IN(CCP_B_IN), .CCP_A_OUT(CCP_A_OUT), .CCP_A_OE(CCP_A_OE),
    .CCP_B_OUT(CCP_B_OUT), .CCP_B_OE(CCP_B_OE), .TRIG_A(TRIG_A),
    .TRIG_B(TRIG_B), .IRQ(IRQ));
  gptm_far_side i_far (.clk(CLK), .halt_req(halt_req),
    .edges_on(edges_on), .debug_halt(DEBUG_HALT), .ccp_a(CCP_A_IN),
    .ccp_b(CCP_B_IN), .rtc_tick(rtc_tick));
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    #1;
    d = RDATA;
  endtask
  task automatic rc(input string nm, input logic [7:0] a, logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(nm, d, e);
  endtask
  task automatic wait_trig(input logic b, output int c);
    c = 0;
    do begin
      @(posedge CLK);
      #1;
      c++;
    end while ((b ? TRIG_B : TRIG_A) !== 1'b1 && c < 40);
  endtask
  task automatic highs(output int h, output int g);
    h = 0;
    g = 0;
    repeat (10) begin
      @(posedge CLK);
      #1;
      if (CCP_A_OUT === 1'b1) h++;
      if (CCP_B_OUT === 1'b1) g++;
    end
  endtask
  task automatic t_reset;
    rc("ctl", `CTL_OFS, 32'h0);
    rc("imr", `IMR_OFS, 32'h0);
    rc("ris", `RIS_OFS, 32'h0);
    rc("unmapped", 8'h10, 32'h0);
    chk("irq", IRQ, 1'b0);
    wr(`CFG_OFS, gptm_pkg::CFG_16_PAIR);
    rc("load_a", `LOAD_A_OFS, 32'hffff);
    wr(`PRE_A_OFS, 32'hff);
    rc("pre_a", `PRE_A_OFS, 32'hff);
    wr(`PMATCH_A_OFS, 32'hff);
    rc("pmatch_a", `PMATCH_A_OFS, 32'hff);
    wr(`PRE_A_OFS, 32'h0);
    wr(`PMATCH_A_OFS, 32'h0);
    wr(`MATCH_A_OFS, 32'h1234);
    rc("match_a", `MATCH_A_OFS, 32'h1234);
    $display("test reset done");
  endtask
  task automatic t_irq;
    wr(`MODE_A_OFS, gptm_pkg::MODE_ONE_SHOT);
    wr(`MODE_B_OFS, gptm_pkg::MODE_CAP_TIME);
    wr(`LOAD_A_OFS, 32'h5);
    wr(`IMR_OFS, 32'h1);
    edges_on <= 1'b1;
    wr(`CTL_OFS, 32'h121);
    wait_trig(1'b0, n);
    chk("trig_a", n < 40, 1'b1);
    repeat (48) @(posedge CLK);
    rc("ris", `RIS_OFS, 32'h401);
    rc("mis", `MIS_OFS, 32'h1);
    rc("value_a", `VALUE_A_OFS, 32'h0);
    chk("irq", IRQ, 1'b1);
    wr(`IMR_OFS, 32'h0);
    repeat (2) @(posedge CLK);
    #1;
    chk("irq", IRQ, 1'b0);
    rc("mis", `MIS_OFS, 32'h0);
    wr(`IMR_OFS, 32'h1);
    wr(`ICR_OFS, 32'h1);
    repeat (2) @(posedge CLK);
    #1;
    chk("irq", IRQ, 1'b0);
    rc("ris", `RIS_OFS, 32'h400);
    edges_on <= 1'b0;
    // Let edges already in the synchroniser land first
    repeat (4) @(posedge CLK);
    wr(`ICR_OFS, 32'h400);
    rc("ris", `RIS_OFS, 32'h0);
    $display("test irq done");
  endtask
  task automatic t_periodic;
    wr(`CTL_OFS, 32'h0);
    wr(`MODE_B_OFS, gptm_pkg::MODE_PERIODIC);
    wr(`LOAD_B_OFS, 32'h3);
    wr(`CTL_OFS, 32'h2100);
    wait_trig(1'b1, n);
    wait_trig(1'b1, n);
    chk("period_b", n, 4);
    wr(`CTL_OFS, 32'h0);
    rd(`VALUE_B_OFS, v);
    repeat (5) @(posedge CLK);
    rc("value_b", `VALUE_B_OFS, v);
    $display("test periodic done");
  endtask
  task automatic t_stall;
    wr(`MODE_A_OFS, gptm_pkg::MODE_PERIODIC);
    wr(`LOAD_A_OFS, 32'h100);
    wr(`CTL_OFS, 32'h3);
    halt_req <= 1'b1;
    repeat (8) @(posedge CLK);
    rd(`VALUE_A_OFS, v);
    repeat (4) @(posedge CLK);
    rc("stalled", `VALUE_A_OFS, v);
    wr(`CTL_OFS, 32'h1);
    rd(`VALUE_A_OFS, v);
    rd(`VALUE_A_OFS, w);
    chk("running", v !== w, 1'b1);
    halt_req <= 1'b0;
    wr(`LOAD_A_OFS, 32'h40);
    rd(`VALUE_A_OFS, v);
    chk("reloaded", v <= 32'h40, 1'b1);
    rc("load_a", `LOAD_A_OFS, 32'h40);
    $display("test stall done");
  endtask
  task automatic t_pwm;
    int h, g;
    wr(`CTL_OFS, 32'h0);
    wr(`MODE_A_OFS, gptm_pkg::MODE_PWM);
    wr(`MODE_B_OFS, gptm_pkg::MODE_PWM);
    wr(`LOAD_A_OFS, 32'h9);
    wr(`MATCH_A_OFS, 32'h2);
    wr(`LOAD_B_OFS, 32'h9);
    wr(`MATCH_B_OFS, 32'h6);
    wr(`CTL_OFS, 32'h101);
    repeat (12) @(posedge CLK);
    #1;
    chk("oe_a", CCP_A_OE, 1'b1);
    chk("oe_b", CCP_B_OE, 1'b1);
    highs(h, g);
    chk("duty", h, 7);
    chk("duty_b", g, 3);
    wr(`CTL_OFS, 32'h141);
    repeat (3) @(posedge CLK);
    highs(h, g);
    chk("inverted", h, 3);
    chk("plain_b", g, 3);
    wr(`CTL_OFS, 32'h0);
    repeat (4) @(posedge CLK);
    #1;
    chk("oe_off", CCP_A_OE, 1'b0);
    chk("oe_b_off", CCP_B_OE, 1'b0);
    $display("test pwm done");
  endtask
  task automatic t_wide;
    wr(`MODE_B_OFS, gptm_pkg::MODE_CAP_COUNT);
    wr(`LOAD_B_OFS, 32'h5);
    wr(`MATCH_B_OFS, 32'h4);
    wr(`ICR_OFS, `IRQ_ALL);
    edges_on <= 1'b1;
    wr(`CTL_OFS, 32'h100);
    repeat (48) @(posedge CLK);
    rc("cap_match", `RIS_OFS, 32'h200);
    wr(`CTL_OFS, 32'h0);
    wr(`CFG_OFS, gptm_pkg::CFG_32_RTC);
    wr(`RTC_MATCH_OFS, 32'h1);
    wr(`ICR_OFS, `IRQ_ALL);
    wr(`IMR_OFS, 32'h8);
    wr(`CTL_OFS, 32'h1);
    repeat (48) @(posedge CLK);
    rc("rtc", `RIS_OFS, 32'h8);
    chk("rtc_irq", IRQ, 1'b1);
    edges_on <= 1'b0;
    wr(`CTL_OFS, 32'h0);
    wr(`CFG_OFS, gptm_pkg::CFG_32_TIMER);
    wr(`PRE_A_OFS, 32'h3);
    wr(`LOAD_A_OFS, 32'h00010002);
    rc("load32", `LOAD_A_OFS, 32'h00010002);
    wr(`CTL_OFS, 32'h1);
    repeat (6) @(posedge CLK);
    rd(`VALUE_A_OFS, v);
    chk("wrap32", v[31:16] == 16'h0 && v[15:0] > 16'hff00, 1'b1);
    @(posedge CLK);
    ce <= 1'b0;
    repeat (5) @(posedge CLK);
    ce <= 1'b1;
    rd(`VALUE_A_OFS, w);
    chk("frozen", w, v - 32'h3);
    wr(`CTL_OFS, 32'h0);
    $display("test wide done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Tests take about 400 cycles
  initial begin
    #400000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    RST_N = 1'b0;
    ce = 1'b1;
    WR = 1'b0;
    RD = 1'b0;
    ADDR = 8'h0;
    WDATA = 32'h0;
    halt_req = 1'b0;
    edges_on = 1'b0;
    repeat (6) @(posedge CLK);
    RST_N <= 1'b1;
    t_reset();
    t_irq();
    t_periodic();
    t_stall();
    t_pwm();
    t_wide();
    report_and_stop();
  end
endmodule
`default_nettype wire
